// *** rtl/alf_pkg.sv ***
// Shared constants and types for the accumulator literal and file datapath.
package alf_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int OPC_W = 14;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // Operation select
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ALF_OP_IDLE,
    ALF_OP_OR_LIT,
    ALF_OP_LOAD_LIT,
    ALF_OP_OR_FILE,
    ALF_OP_STORE,
    ALF_OP_COPY
  } alf_op_t;

  // ----------------------------------------------------------------------
  // Instruction word encodings
  // ----------------------------------------------------------------------
  localparam logic [13:0] ENC_IDLE = 14'h0000;
  localparam logic [5:0] ENC_OR_LIT = 6'h38;
  localparam logic [3:0] ENC_LOAD_LIT = 4'h3;
  localparam logic [5:0] ENC_OR_FILE = 6'h04;
  localparam logic [6:0] ENC_STORE = 7'h01;
  localparam logic [5:0] ENC_COPY = 6'h08;
  localparam int DEST_BIT = 7;

endpackage

// *** rtl/alf_decode.sv ***
// Instruction decoder for the accumulator literal and file datapath.
`timescale 1ns/1ps
module alf_decode (
  // Instruction word
  input wire logic [13:0] i_instr,
  // Decoded fields
  output alf_pkg::alf_op_t o_op,
  output logic o_dest_file,
  output logic [6:0] o_addr,
  output logic [7:0] o_literal
);

  wire is_or_lit = (i_instr[13:8] == alf_pkg::ENC_OR_LIT);
  wire is_load = (i_instr[13:10] == alf_pkg::ENC_LOAD_LIT);
  wire is_or_file = (i_instr[13:8] == alf_pkg::ENC_OR_FILE);
  wire is_store = (i_instr[13:7] == alf_pkg::ENC_STORE);
  wire is_copy = (i_instr[13:8] == alf_pkg::ENC_COPY);

  assign o_op = is_or_lit ? alf_pkg::ALF_OP_OR_LIT :
                is_load ? alf_pkg::ALF_OP_LOAD_LIT :
                is_or_file ? alf_pkg::ALF_OP_OR_FILE :
                is_store ? alf_pkg::ALF_OP_STORE :
                is_copy ? alf_pkg::ALF_OP_COPY : alf_pkg::ALF_OP_IDLE;
  assign o_dest_file = i_instr[alf_pkg::DEST_BIT];
  assign o_addr = i_instr[6:0];
  assign o_literal = i_instr[7:0];

endmodule

// *** rtl/alf_core.sv ***
// Execution datapath for five accumulator and file register instructions.
`timescale 1ns/1ps
// Functional notes
// - OR literal into accumulator, result to accumulator, zero flag updated.
// - Load literal into accumulator unchanged, flags untouched.
// - OR accumulator with file; destination bit picks accumulator or file; zero updated.
// - Store accumulator into addressed file register, flags untouched.
// - Copy file register to accumulator or back to itself per destination bit.
// - Copy updates zero flag for either destination.
module alf_core (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Instruction issue
  input wire logic i_valid,
  input wire logic [13:0] i_instr,
  // File register read data for the addressed register
  input wire logic [7:0] i_file_rdata,
  // File register access
  output logic [6:0] o_file_addr,
  output logic o_file_we,
  output logic [7:0] o_file_wdata,
  // Architectural state
  output logic [7:0] o_acc,
  output logic o_zero,
  output logic o_done
);

  alf_pkg::alf_op_t op;
  logic dest_file;
  logic [7:0] literal;

  alf_decode u_dec (
    .i_instr(i_instr),
    .o_op(op),
    .o_dest_file(dest_file),
    .o_addr(o_file_addr),
    .o_literal(literal)
  );

  // ----------------------------------------------------------------------
  // Result selection
  // ----------------------------------------------------------------------
  wire op_or_lit = i_valid && (op == alf_pkg::ALF_OP_OR_LIT);
  wire op_load = i_valid && (op == alf_pkg::ALF_OP_LOAD_LIT);
  wire op_or_file = i_valid && (op == alf_pkg::ALF_OP_OR_FILE);
  wire op_store = i_valid && (op == alf_pkg::ALF_OP_STORE);
  wire op_copy = i_valid && (op == alf_pkg::ALF_OP_COPY);

  logic [7:0] acc_reg, acc_next;
  logic zero_reg, zero_next;
  logic done_reg;

  wire [7:0] or_lit_res = acc_reg | literal;
  wire [7:0] or_file_res = acc_reg | i_file_rdata;
  wire [7:0] result = op_or_lit ? or_lit_res :
                      op_or_file ? or_file_res :
                      op_load ? literal : i_file_rdata;
  wire file_op = op_or_file || op_copy;
  wire acc_we = op_or_lit || op_load || (file_op && !dest_file);
  wire zero_we = op_or_lit || file_op;

  assign acc_next = acc_we ? result : acc_reg;
  assign zero_next = zero_we ? (result == 8'h00) : zero_reg;
  assign o_file_we = op_store || (file_op && dest_file);
  assign o_file_wdata = op_store ? acc_reg : result;

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= alf_pkg::ACC_RESET;
      zero_reg <= alf_pkg::ZERO_RESET;
      done_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      zero_reg <= zero_next;
      done_reg <= i_valid;
    end
  end

  assign o_acc = acc_reg;
  assign o_zero = zero_reg;
  assign o_done = done_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Literal operations land in the accumulator one edge later and never touch the file.
  or_lit_acc_a: assert property (op_or_lit |=>
    o_acc == ($past(acc_reg) | $past(literal)) && o_zero == (o_acc == 8'h00))
    else $error("or literal result wrong");
  lit_no_write_a: assert property ((op_or_lit || op_load) |-> !o_file_we)
    else $error("literal op wrote a file register");
  load_lit_a: assert property (op_load |=> o_acc == $past(literal) && $stable(o_zero))
    else $error("load literal wrong");

  // File operations write back in the same cycle when the destination bit is set.
  or_file_dst_a: assert property (op_or_file && dest_file |-> o_file_we
    && o_file_wdata == (acc_reg | i_file_rdata) ##1 $stable(o_acc))
    else $error("or file to file wrong");
  or_file_acc_a: assert property (op_or_file && !dest_file |-> !o_file_we
    ##1 o_acc == ($past(acc_reg) | $past(i_file_rdata)))
    else $error("or file to acc wrong");
  or_file_zero_a: assert property (op_or_file |=>
    o_zero == (($past(acc_reg) | $past(i_file_rdata)) == 8'h00))
    else $error("or file zero flag wrong");
  store_acc_a: assert property (op_store |-> o_file_we && o_file_wdata == acc_reg
    ##1 $stable(o_zero) && $stable(o_acc))
    else $error("store wrong");
  copy_dest_a: assert property (op_copy && !dest_file |=> o_acc == $past(i_file_rdata))
    else $error("copy to acc wrong");
  copy_file_a: assert property (op_copy && dest_file |-> o_file_we
    && o_file_wdata == i_file_rdata ##1 $stable(o_acc))
    else $error("copy to file wrong");
  copy_zero_a: assert property (op_copy |=> o_zero == ($past(i_file_rdata) == 8'h00))
    else $error("copy zero flag wrong");

  // Idle words, unknown words and empty cycles leave the accumulator, zero flag and file alone; done still follows valid.
  idle_quiet_a: assert property (i_valid && op == alf_pkg::ALF_OP_IDLE |-> !o_file_we
    ##1 $stable(o_acc) && $stable(o_zero) && o_done)
    else $error("idle changed state");
  idle_code_a: assert property (i_valid && i_instr == alf_pkg::ENC_IDLE |->
    op == alf_pkg::ALF_OP_IDLE)
    else $error("idle word not decoded as idle");
  no_issue_a: assert property (!i_valid |-> !o_file_we
    ##1 $stable(o_acc) && $stable(o_zero) && !o_done)
    else $error("state changed without an instruction");

  or_lit_zero_c: cover property (op_or_lit ##1 o_zero);
  copy_test_c: cover property (op_copy && dest_file ##1 o_zero);
  store_c: cover property (op_load ##1 op_store);
  idle_c: cover property (i_valid && op == alf_pkg::ALF_OP_IDLE);
  or_file_dst_c: cover property (op_or_file && dest_file ##1 !o_zero);

endmodule

// *** sim/alf_core_tb.sv ***
// Self-checking testbench for the accumulator literal and file datapath.
`timescale 1ns/1ps
module alf_core_tb;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_valid = 1'b0;
  logic [13:0] i_instr = 14'h0000;
  logic [7:0] i_file_rdata = 8'h00;
  logic [6:0] o_file_addr;
  logic o_file_we;
  logic [7:0] o_file_wdata;
  logic [7:0] o_acc;
  logic o_zero;
  logic o_done;
  int n_fail = 0;
  int n_compared = 0;

  alf_core alf_core_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .i_instr(i_instr), .i_file_rdata(i_file_rdata), .o_file_addr(o_file_addr),
    .o_file_we(o_file_we), .o_file_wdata(o_file_wdata), .o_acc(o_acc), .o_zero(o_zero),
    .o_done(o_done));

  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Issues one instruction at a falling edge and judges both cycles of it.
  task automatic ex(input logic [13:0] ins, input logic [7:0] rd, input logic we,
                    input logic [7:0] wd, input logic [7:0] acc, input logic z);
    i_instr = ins;
    i_file_rdata = rd;
    i_valid = 1'b1;
    #1;
    chk({7'h00, o_file_we}, {7'h00, we});
    chk({1'h0, o_file_addr}, {1'h0, ins[6:0]});
    if (we) chk(o_file_wdata, wd);
    @(negedge i_core_clk);
    chk(o_acc, acc);
    chk({7'h00, o_zero}, {7'h00, z});
    chk({7'h00, o_done}, 8'h01);
  endtask

  task automatic t_or_lit;
    ex(14'h3800, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    ex(14'h3881, 8'h00, 1'b0, 8'h00, 8'h81, 1'b0);
    ex(14'h385a, 8'hff, 1'b0, 8'h00, 8'hdb, 1'b0);
  endtask

  task automatic t_load;
    ex(14'h0f00, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    ex(14'h3800, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    ex(14'h0fa5, 8'h00, 1'b0, 8'h00, 8'ha5, 1'b1);
  endtask

  task automatic t_store;
    ex(14'h00c5, 8'h33, 1'b1, 8'ha5, 8'ha5, 1'b1);
  endtask

  task automatic t_or_file;
    ex(14'h04ff, 8'h5a, 1'b1, 8'hff, 8'ha5, 1'b0);
    ex(14'h0412, 8'h0a, 1'b0, 8'h00, 8'haf, 1'b0);
  endtask

  task automatic t_copy;
    ex(14'h0803, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    ex(14'h0880, 8'h77, 1'b1, 8'h77, 8'h00, 1'b0);
  endtask

  task automatic t_idle;
    ex(14'h0803, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    ex(14'h0000, 8'hff, 1'b0, 8'h00, 8'h00, 1'b1);
    ex(14'h3fff, 8'hff, 1'b0, 8'h00, 8'h00, 1'b1);
    i_valid = 1'b0;
    i_instr = 14'h38ff;
    @(negedge i_core_clk);
    chk({7'h00, o_done}, 8'h00);
    chk(o_acc, 8'h00);
    chk({7'h00, o_zero}, 8'h01);
  endtask

  task automatic finish_test;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    @(negedge i_core_clk);
    t_or_lit();
    t_load();
    t_store();
    t_or_file();
    t_copy();
    t_idle();
    finish_test();
  end
endmodule
